/* File: pkg/intpwr_map.svh */
// Constants for the interrupt and power control link and registers
// Summary of operation
// - Six vectors: two pins, three timers, serial
// - Global enable bit seven gates every request
// - Bit five enables timer 2 request
// - Bit four enables shared SPI and UART
// - Bits zero to three enable pins, timers
// - Software never writes one to bit six
// - Timer 2 request ORs overflow, external flags
// - Timer 2 flags survive vectoring; software clears
// - Timer 0/1 flags set state5_phase2, polled next
// - Timer 2 flag set state2_phase2, polled same
// - Internal clock via divide-by-two flip-flop
// - Idle stops CPU; peripherals, registers keep running
// - Idle ends on enabled interrupt or reset
// - Reset from idle: two cycles, RAM writes blocked
// - Instruction after idle avoids port writes
// - Power-down stops oscillator, keeps RAM, registers
// - Power-down ends by reset or external interrupt
// - Software enables level external interrupt first
// - Wake from power-down after nominal 16 ms
// - Strobes high in idle, low in power-down
// - SPI request needs SPI and serial enables
`ifndef INTPWR_MAP_SVH
`define INTPWR_MAP_SVH

// Enable mask bit positions
`define MSK_EXT0_BIT     0
`define MSK_T0_BIT       1
`define MSK_EXT1_BIT     2
`define MSK_T1_BIT       3
`define MSK_SERIAL_BIT   4
`define MSK_T2_BIT       5
`define MSK_RSVD_BIT     6
`define MSK_GLOBAL_BIT   7
`define MSK_RESET        8'h00

// Machine cycle timing
`define MC_STATES        6
`define POLL_STATE       5
`define T2_SET_STATE     2
`define RST_RUN_MC       2

// Oscillator restart after power-down wake
`define WAKE_TIME_MS     16
`define CLK_MHZ          125
`define WAKE_CYCLES      (`WAKE_TIME_MS * 1000 * `CLK_MHZ)

// Host register offsets
`define REG_MSK_OFS      8'h00
`define REG_CMD_OFS      8'h04
`define REG_STAT_OFS     8'h08

// Command register bits
`define CMD_IDLE_BIT     0
`define CMD_PDOWN_BIT    1
`define CMD_CLR_T2F_BIT  2
`define CMD_CLR_T2X_BIT  3
`define CMD_SPI_EN_BIT   4

// Status register fields
`define ST_VEC_LSB       0
`define ST_MODE_LSB      4
`define ST_T2_LSB        6
`define ST_CRST_BIT      8
`define ST_SPI_EN_BIT    9
`define ST_CNT_LSB       16

`endif

/* File: pkg/intpwr_pkg.sv */
// Types shared by both ends of the interrupt and power link
package intpwr_pkg;
    // Power mode, Gray coded along run, power-down, wake, idle
    typedef enum logic [1:0] {
        MODE_RUN   = 2'b00,
        MODE_PDOWN = 2'b01,
        MODE_WAKE  = 2'b11,
        MODE_IDLE  = 2'b10
    } mode_t;

    // Vector numbers, equal to the enable bit of each source
    typedef enum logic [2:0] {
        VEC_EXT0   = 3'h0,
        VEC_T0     = 3'h1,
        VEC_EXT1   = 3'h2,
        VEC_T1     = 3'h3,
        VEC_SERIAL = 3'h4,
        VEC_T2     = 3'h5
    } vector_t;
endpackage : intpwr_pkg

/* File: pkg/irq_link_if.sv */
// Link between the interrupt/power controller and the CPU sequencer
`timescale 1ns/1ns
`default_nettype none
interface irq_link_if;
    import intpwr_pkg::*;
    logic       msk_wr;
    logic [7:0] msk_wdata;
    logic [7:0] msk_q;
    logic       spi_en;
    logic [1:0] t2_clr;
    logic       idle_cmd;
    logic       pd_cmd;
    logic       irq_valid;
    vector_t    irq_vector;
    logic       irq_ack;
    mode_t      mode;
    logic [1:0] t2_flags;
    logic       core_reset;

    modport device (
        input  msk_wr, msk_wdata, spi_en, t2_clr, idle_cmd, pd_cmd, irq_ack,
        output msk_q, irq_valid, irq_vector, mode, t2_flags, core_reset
    );
    modport host (
        output msk_wr, msk_wdata, spi_en, t2_clr, idle_cmd, pd_cmd, irq_ack,
        input  msk_q, irq_valid, irq_vector, mode, t2_flags, core_reset
    );
endinterface : irq_link_if
`default_nettype wire

/* File: core/interrupt_power_control.sv */
// Interrupt enable, flag timing and idle/power-down control
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "intpwr_map.svh"
module interrupt_power_control
    import intpwr_pkg::*;
#(
    parameter int unsigned WAKE_CYCLES = `WAKE_CYCLES
) (
    // Clock, reset, enable
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic   ce,
    // Link to the CPU sequencer
    irq_link_if.device  link,
    // Hardware reset pin, synchronous level
    input  wire logic   rst_pin,
    // External interrupt pins, active low levels
    input  wire logic   ext_interrupt_pin_0_n,
    input  wire logic   ext_interrupt_pin_1_n,
    // Peripheral flag sources
    input  wire logic   timer0_overflow,
    input  wire logic   timer1_overflow,
    input  wire logic   timer2_overflow,
    input  wire logic   timer2_external,
    input  wire logic   uart_flag,
    input  wire logic   spi_flag,
    // Core strobes and program memory select
    input  wire logic   ale_core,
    input  wire logic   program_store_strobe_core,
    input  wire logic   ext_program,
    // Power state outputs
    output logic        cpu_stall,
    output logic        osc_stop,
    output logic        ram_write_block,
    output logic        ale_out,
    output logic        program_store_strobe,
    output logic        port0_float,
    output logic        port2_address
);
    localparam logic [2:0] LAST_STATE = 3'(`MC_STATES - 1);
    localparam logic [2:0] POLL_ST    = 3'(`POLL_STATE);
    localparam logic [2:0] T2_ST      = 3'(`T2_SET_STATE);
    localparam logic [1:0] RST_MC     = 2'(`RST_RUN_MC);
    localparam logic [31:0] WAKE_LAST = 32'(WAKE_CYCLES - 1);

    logic       phase_r;
    logic [2:0] state_r;
    mode_t      mode_r;
    mode_t      mode_nxt;
    logic [7:0] msk_r;
    logic       ev0_r;
    logic       ev1_r;
    logic       ev2_r;
    logic       evx_r;
    logic       t0f_r;
    logic       t1f_r;
    logic       t2f_r;
    logic       t2x_r;
    logic       valid_r;
    vector_t    vector_r;
    logic [1:0] rst_mc_r;
    logic       rst_run_r;
    logic       core_reset_r;
    logic [31:0] wake_cnt_r;
    logic       cpu_stall_r;
    logic       osc_stop_r;
    logic       rblk_r;
    logic       ale_r;
    logic       pss_r;
    logic       p0f_r;
    logic       p2a_r;

    // Machine timing runs while the oscillator runs
    wire osc_run   = (mode_r == MODE_RUN) || (mode_r == MODE_IDLE);
    wire step      = ce && osc_run;
    wire poll_pt   = phase_r && (state_r == POLL_ST);
    wire t2_pt     = phase_r && (state_r == T2_ST);
    wire asleep    = (mode_r != MODE_RUN);
    wire sreset    = rst_pin && !rst_run_r && (mode_r != MODE_IDLE);
    wire ack       = link.irq_ack && valid_r;

    // Source flags, bit order matches the enable mask
    wire [5:0] src = {t2f_r | t2x_r,
                      uart_flag | (spi_flag & link.spi_en),
                      t1f_r,
                      !ext_interrupt_pin_1_n,
                      t0f_r,
                      !ext_interrupt_pin_0_n};
    wire [5:0] enabled = src & msk_r[5:0] & {6{msk_r[`MSK_GLOBAL_BIT]}};
    wire       ext_wake = msk_r[`MSK_GLOBAL_BIT] &&
                          ((!ext_interrupt_pin_0_n && msk_r[`MSK_EXT0_BIT]) ||
                           (!ext_interrupt_pin_1_n && msk_r[`MSK_EXT1_BIT]));

    // Fixed priority: lowest vector number wins
    vector_t first;
    always_comb begin
        first = VEC_EXT0;
        for (int i = 5; i >= 0; i--) begin
            if (enabled[i]) begin
                first = vector_t'(3'(i));
            end
        end
    end

    // Power mode transitions
    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            MODE_RUN: begin
                if (link.pd_cmd) begin
                    mode_nxt = MODE_PDOWN;
                end else if (link.idle_cmd) begin
                    mode_nxt = MODE_IDLE;
                end
            end
            MODE_IDLE: begin
                if (rst_pin || (poll_pt && |enabled)) begin
                    mode_nxt = MODE_RUN;
                end
            end
            MODE_PDOWN: begin
                if (ext_wake) begin
                    mode_nxt = MODE_WAKE;
                end
            end
            MODE_WAKE: begin
                if (wake_cnt_r == WAKE_LAST) begin
                    mode_nxt = MODE_RUN;
                end
            end
        endcase
        if (rst_pin && mode_r != MODE_IDLE) begin
            mode_nxt = MODE_RUN;
        end
    end

    // Divide-by-two phase and state counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= 1'b0;
            state_r <= 3'h0;
        end else if (step) begin
            phase_r <= !phase_r;
            if (phase_r) begin
                state_r <= (state_r == LAST_STATE) ? 3'h0 : state_r + 3'h1;
            end
        end
    end

    // Enable mask; a hardware reset reinitialises it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msk_r <= `MSK_RESET;
        end else if (ce) begin
            if (core_reset_r) begin
                msk_r <= `MSK_RESET;
            end else if (link.msk_wr && !asleep) begin
                msk_r <= link.msk_wdata;
            end
        end
    end

    // Timer flags; set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev0_r  <= 1'b0;
            ev1_r  <= 1'b0;
            ev2_r  <= 1'b0;
            evx_r  <= 1'b0;
            t0f_r  <= 1'b0;
            t1f_r  <= 1'b0;
            t2f_r  <= 1'b0;
            t2x_r  <= 1'b0;
        end else if (ce) begin
            ev0_r  <= timer0_overflow | (ev0_r & !(step & poll_pt));
            ev1_r  <= timer1_overflow | (ev1_r & !(step & poll_pt));
            ev2_r  <= timer2_overflow | (ev2_r & !(step & t2_pt));
            evx_r  <= timer2_external | (evx_r & !(step & t2_pt));
            t0f_r  <= (step & poll_pt & ev0_r) |
                      (t0f_r & !(ack && vector_r == VEC_T0) & !core_reset_r);
            t1f_r  <= (step & poll_pt & ev1_r) |
                      (t1f_r & !(ack && vector_r == VEC_T1) & !core_reset_r);
            t2f_r  <= (step & t2_pt & ev2_r) |
                      (t2f_r & !link.t2_clr[0] & !core_reset_r);
            t2x_r  <= (step & t2_pt & evx_r) |
                      (t2x_r & !link.t2_clr[1] & !core_reset_r);
        end
    end

    // Poll once per machine cycle at state5_phase2
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_r  <= 1'b0;
            vector_r <= VEC_EXT0;
        end else if (ce) begin
            if (core_reset_r) begin
                valid_r <= 1'b0;
            end else if (step && poll_pt && mode_r == MODE_RUN && !valid_r) begin
                valid_r  <= |enabled;
                vector_r <= first;
            end else if (ack) begin
                valid_r <= 1'b0;
            end
        end
    end

    // Reset ending idle runs two more machine cycles first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_mc_r     <= 2'h0;
            rst_run_r    <= 1'b0;
            core_reset_r <= 1'b0;
        end else if (ce) begin
            if (mode_r == MODE_IDLE && rst_pin) begin
                rst_run_r <= 1'b1;
                rst_mc_r  <= RST_MC;
            end else if (rst_run_r && step && poll_pt) begin
                rst_mc_r  <= rst_mc_r - 2'h1;
                rst_run_r <= (rst_mc_r != 2'h1);
            end
            core_reset_r <= sreset;
        end
    end

    // Oscillator restart delay after wake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_cnt_r <= 32'h0;
        end else if (ce) begin
            wake_cnt_r <= (mode_r == MODE_WAKE) ? wake_cnt_r + 32'h1 : 32'h0;
        end
    end

    // Mode register and pin states while asleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r      <= MODE_RUN;
            cpu_stall_r <= 1'b0;
            osc_stop_r  <= 1'b0;
            rblk_r      <= 1'b0;
            ale_r       <= 1'b0;
            pss_r       <= 1'b0;
            p0f_r       <= 1'b0;
            p2a_r       <= 1'b0;
        end else if (ce) begin
            mode_r      <= mode_nxt;
            cpu_stall_r <= (mode_nxt != MODE_RUN);
            osc_stop_r  <= (mode_nxt == MODE_PDOWN);
            rblk_r      <= rst_run_r || rst_pin;
            ale_r       <= (mode_nxt == MODE_IDLE) ? 1'b1 :
                           (mode_nxt == MODE_RUN) ? ale_core : 1'b0;
            pss_r       <= (mode_nxt == MODE_IDLE) ? 1'b1 :
                           (mode_nxt == MODE_RUN) ? program_store_strobe_core : 1'b0;
            p0f_r       <= ext_program && (mode_nxt != MODE_RUN);
            p2a_r       <= ext_program && (mode_nxt == MODE_IDLE);
        end
    end

    // Outputs come straight from flip-flops
    assign link.msk_q      = msk_r;
    assign link.irq_valid  = valid_r;
    assign link.irq_vector = vector_r;
    assign link.mode       = mode_r;
    assign link.t2_flags   = {t2x_r, t2f_r};
    assign link.core_reset = core_reset_r;
    assign cpu_stall            = cpu_stall_r;
    assign osc_stop             = osc_stop_r;
    assign ram_write_block      = rblk_r;
    assign ale_out              = ale_r;
    assign program_store_strobe = pss_r;
    assign port0_float          = p0f_r;
    assign port2_address        = p2a_r;
endmodule : interrupt_power_control
`default_nettype wire

/* File: core/cpu_irq_sequencer.sv */
// CPU-side sequencer: APB registers, vector acknowledge, mode commands
`timescale 1ns/1ns
`default_nettype none
`include "intpwr_map.svh"
module cpu_irq_sequencer
    import intpwr_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Link to the interrupt/power controller
    irq_link_if.host         link
);
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        msk_wr_r;
    logic [7:0]  msk_wdata_r;
    logic        spi_en_r;
    logic [1:0]  t2_clr_r;
    logic        idle_r;
    logic        pd_r;
    logic        ack_r;
    vector_t     last_vec_r;
    logic [7:0]  vec_cnt_r;

    // Address decode and read selection
    wire hit_msk  = (paddr == `REG_MSK_OFS);
    wire hit_cmd  = (paddr == `REG_CMD_OFS);
    wire hit_stat = (paddr == `REG_STAT_OFS);
    wire mapped   = hit_msk || hit_cmd || hit_stat;
    wire setup    = psel && !penable && !pready_r;
    wire wr_done  = psel && penable && pready_r && pwrite && !pslverr_r;
    wire [31:0] stat_word = (32'(last_vec_r) << `ST_VEC_LSB) |
                            (32'(link.mode) << `ST_MODE_LSB) |
                            (32'(link.t2_flags) << `ST_T2_LSB) |
                            (32'(link.core_reset) << `ST_CRST_BIT) |
                            (32'(spi_en_r) << `ST_SPI_EN_BIT) |
                            (32'(vec_cnt_r) << `ST_CNT_LSB);
    wire [31:0] rd_word   = hit_msk ? {24'h0, link.msk_q} :
                            hit_stat ? stat_word : 32'h0;

    // Answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (ce) begin
            pready_r  <= setup;
            pslverr_r <= setup && !mapped;
            if (setup) begin
                prdata_r <= pwrite ? 32'h0 : rd_word;
            end
        end
    end

    // Register writes become link pulses; the SPI enable is held as a level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msk_wr_r    <= 1'b0;
            msk_wdata_r <= 8'h00;
            spi_en_r   <= 1'b0;
            t2_clr_r   <= 2'h0;
            idle_r     <= 1'b0;
            pd_r       <= 1'b0;
        end else if (ce) begin
            msk_wr_r <= wr_done && hit_msk;
            t2_clr_r <= (wr_done && hit_cmd) ?
                        {pwdata[`CMD_CLR_T2X_BIT], pwdata[`CMD_CLR_T2F_BIT]} : 2'h0;
            idle_r   <= wr_done && hit_cmd && pwdata[`CMD_IDLE_BIT];
            pd_r     <= wr_done && hit_cmd && pwdata[`CMD_PDOWN_BIT];
            if (wr_done && hit_msk) begin
                msk_wdata_r <= pwdata[7:0] & ~(8'h01 << `MSK_RSVD_BIT);
            end
            if (link.core_reset) begin
                spi_en_r <= 1'b0;
            end else if (wr_done && hit_cmd) begin
                spi_en_r <= pwdata[`CMD_SPI_EN_BIT];
            end
        end
    end

    // Vector acknowledge while the core runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_r      <= 1'b0;
            last_vec_r <= VEC_EXT0;
            vec_cnt_r  <= 8'h00;
        end else if (ce) begin
            ack_r <= link.irq_valid && !ack_r && (link.mode == MODE_RUN);
            if (link.irq_valid && !ack_r && link.mode == MODE_RUN) begin
                last_vec_r <= link.irq_vector;
                vec_cnt_r  <= vec_cnt_r + 8'h01;
            end
        end
    end

    // Outputs straight from flip-flops
    assign prdata        = prdata_r;
    assign pready        = pready_r;
    assign pslverr       = pslverr_r;
    assign link.msk_wr    = msk_wr_r;
    assign link.msk_wdata = msk_wdata_r;
    assign link.spi_en   = spi_en_r;
    assign link.t2_clr   = t2_clr_r;
    assign link.idle_cmd = idle_r;
    assign link.pd_cmd   = pd_r;
    assign link.irq_ack  = ack_r;
endmodule : cpu_irq_sequencer
`default_nettype wire

/* File: dv/irq_link_sva.sv */
// Checker for the link between the interrupt controller and the CPU sequencer
`timescale 1ns/1ns
`default_nettype none
module irq_link_sva
    import intpwr_pkg::*;
#(
    parameter int WAKE_CYCLES = 20
) (
    // Clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // Link signals
    input wire logic       msk_wr,
    input wire logic [7:0] msk_wdata,
    input wire logic [7:0] msk_q,
    input wire logic       irq_valid,
    input wire vector_t    irq_vector,
    input wire logic       irq_ack,
    input wire mode_t      mode,
    input wire logic [1:0] t2_flags,
    input wire logic [1:0] t2_clr,
    input wire logic       core_reset,
    input wire logic       idle_cmd,
    input wire logic       pd_cmd
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    int wake_cnt;

    // Counts cycles spent waiting for the oscillator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_cnt <= 0;
        end else begin
            wake_cnt <= (mode == MODE_WAKE) ? wake_cnt + 1 : 0;
        end
    end

    // Register, vectoring and power-mode relations
    mask_write_a: assert property (msk_wr && mode == MODE_RUN && !core_reset
        |=> msk_q == msk_wdata)
        else $error("mask write lost");
    global_gate_a: assert property ($rose(irq_valid) |-> $past(msk_q[7]))
        else $error("request without global enable");
    source_gate_a: assert property ($rose(irq_valid)
        |-> ($past(msk_q) & (8'h01 << irq_vector)) != 8'h00)
        else $error("request without source enable");
    vector_range_a: assert property (irq_valid |-> irq_vector <= VEC_T2)
        else $error("vector out of range");
    ack_drop_a: assert property (irq_valid && irq_ack |=> !irq_valid)
        else $error("request held after ack");
    t2_cause_a: assert property ($rose(irq_valid) && irq_vector == VEC_T2 |-> $past(t2_flags) != 2'b00)
        else $error("timer 2 vector without flag");
    t2_keep_a: assert property (irq_ack && irq_vector == VEC_T2 && t2_clr == 2'b00 && !core_reset
        |=> (t2_flags & $past(t2_flags)) == $past(t2_flags))
        else $error("timer 2 flag cleared by vectoring");
    idle_enter_a: assert property (idle_cmd && !pd_cmd && mode == MODE_RUN && !core_reset
        |=> mode == MODE_IDLE)
        else $error("idle not entered");
    pdown_enter_a: assert property (pd_cmd && mode == MODE_RUN && !core_reset |=> mode == MODE_PDOWN)
        else $error("power-down not entered");
    pdown_exit_a: assert property (mode == MODE_PDOWN |=> mode != MODE_IDLE)
        else $error("power-down left to idle");
    wake_len_a: assert property (mode == MODE_WAKE |-> wake_cnt < WAKE_CYCLES + 2)
        else $error("wake too long");
    reset_clear_a: assert property (core_reset && $past(core_reset) |-> msk_q == 8'h00)
        else $error("mask kept during reset");

    // Main scenarios
    cover property ($rose(irq_valid) && irq_vector == VEC_T2);
    cover property (mode == MODE_IDLE ##1 mode == MODE_RUN);
    cover property (mode == MODE_WAKE ##1 mode == MODE_RUN);
endmodule : irq_link_sva
`default_nettype wire

/* File: dv/testbench.sv */
// Testbench joining both ends of the interrupt and power link
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import intpwr_pkg::*;
    logic        pclk, presetn, ce, rst_pin, ext0_n, ext1_n, ext_prog;
    logic        t0, t1, t2o, t2x, uart, spi, ale_c, pss_c;
    logic        psel, penable, pwrite, pready, pslverr, perr;
    logic        stall, osc_stop, ram_wb, ale_o, pss_o, p0f, p2a;
    logic [7:0]  paddr, base;
    logic [31:0] pwdata, prdata, s;
    int          fails = 0;
    int          num_checks = 0;

    // Both ends, the link between them and its checker
    irq_link_if link();
    interrupt_power_control #(.WAKE_CYCLES(20)) i_interrupt_power_control (
        .pclk(pclk), .presetn(presetn), .ce(ce), .link(link.device), .rst_pin(rst_pin),
        .ext_interrupt_pin_0_n(ext0_n), .ext_interrupt_pin_1_n(ext1_n),
        .timer0_overflow(t0), .timer1_overflow(t1), .timer2_overflow(t2o),
        .timer2_external(t2x), .uart_flag(uart), .spi_flag(spi), .ale_core(ale_c),
        .program_store_strobe_core(pss_c), .ext_program(ext_prog), .cpu_stall(stall),
        .osc_stop(osc_stop), .ram_write_block(ram_wb), .ale_out(ale_o),
        .program_store_strobe(pss_o), .port0_float(p0f), .port2_address(p2a));
    cpu_irq_sequencer i_cpu_irq_sequencer (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link.host));
    irq_link_sva #(.WAKE_CYCLES(20)) i_irq_link_sva (
        .pclk(pclk), .presetn(presetn), .msk_wr(link.msk_wr), .msk_wdata(link.msk_wdata),
        .msk_q(link.msk_q), .irq_valid(link.irq_valid), .irq_vector(link.irq_vector),
        .irq_ack(link.irq_ack), .mode(link.mode), .t2_flags(link.t2_flags),
        .t2_clr(link.t2_clr), .core_reset(link.core_reset), .idle_cmd(link.idle_cmd),
        .pd_cmd(link.pd_cmd));

    // Free-running 125 MHz clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk1

    // One APB transfer: setup, access held until pready, then release
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) chk1(pready, 1'b1);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rd

    // Status snapshot, and wait for the vector count to move on
    task automatic snap();
        apb(1'b0, 8'h08, 32'h0, s);
        base = s[23:16];
    endtask : snap

    task automatic wait_vec(input logic [2:0] v);
        int n;
        n = 0;
        do apb(1'b0, 8'h08, 32'h0, s); while (s[23:16] === base && ++n < 100);
        chk1(s[23:16] !== base, 1'b1);
        chk({29'h0, s[2:0]}, {29'h0, v});
    endtask : wait_vec

    task automatic src(input int k, input logic on);
        case (k)
            0: ext0_n <= !on;
            1: t0 <= on;
            2: ext1_n <= !on;
            3: t1 <= on;
            4: uart <= on;
            default: t2o <= on;
        endcase
    endtask : src

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    // Watchdog against a hung handshake
    initial begin
        repeat (30000) @(posedge pclk);
        fails++;
        report_and_stop();
    end

    // Test sequence
    initial begin
        {presetn, psel, penable, pwrite, t0, t1, t2o, t2x, uart, spi, rst_pin} = '0;
        {ce, ext0_n, ext1_n, ext_prog, ale_c, pss_c} = '1;
        {paddr, pwdata} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(8'h00, 32'h0);
        rd(8'h0C, 32'h0);
        chk1(perr, 1'b1);
        wr(8'h00, 32'h7F);
        rd(8'h00, 32'h3F);
        for (int k = 0; k < 6; k++) begin
            wr(8'h00, 32'h80 | (32'h1 << k));
            snap();
            src(k, 1'b1);
            wait_vec(k[2:0]);
            src(k, 1'b0);
        end
        // Let a still latched timer event land before the flags are read
        repeat (12) @(posedge pclk);
        apb(1'b0, 8'h08, 32'h0, s);
        chk({30'h0, s[7:6]}, 32'h1);
        wr(8'h04, 32'h04);
        snap();
        chk({30'h0, s[7:6]}, 32'h0);
        t2x <= 1'b1;
        wait_vec(3'h5);
        t2x <= 1'b0;
        repeat (12) @(posedge pclk);
        chk({30'h0, s[7:6]}, 32'h2);
        wr(8'h04, 32'h08);
        wr(8'h00, 32'h02);
        snap();
        chk({30'h0, s[7:6]}, 32'h0);
        src(1, 1'b1);
        repeat (36) @(posedge pclk);
        src(1, 1'b0);
        apb(1'b0, 8'h08, 32'h0, s);
        chk({24'h0, s[23:16]}, {24'h0, base});
        wr(8'h00, 32'h82);
        wait_vec(3'h1);
        wr(8'h00, 32'h90);
        snap();
        spi <= 1'b1;
        repeat (36) @(posedge pclk);
        apb(1'b0, 8'h08, 32'h0, s);
        chk({24'h0, s[23:16]}, {24'h0, base});
        wr(8'h04, 32'h10);
        wait_vec(3'h4);
        spi <= 1'b0;
        wr(8'h04, 32'h00);
        {ale_c, pss_c} <= 2'b00;
        wr(8'h00, 32'h81);
        wr(8'h04, 32'h01);
        repeat (3) @(posedge pclk);
        chk({27'h0, stall, ale_o, pss_o, p0f, p2a}, 32'h1F);
        snap();
        ext0_n <= 1'b0;
        wait_vec(3'h0);
        ext0_n <= 1'b1;
        chk1(stall, 1'b0);
        {ale_c, pss_c} <= 2'b11;
        wr(8'h04, 32'h02);
        repeat (3) @(posedge pclk);
        chk({27'h0, osc_stop, ale_o, pss_o, p0f, p2a}, 32'h12);
        snap();
        ext0_n <= 1'b0;
        wait_vec(3'h0);
        ext0_n <= 1'b1;
        chk1(osc_stop, 1'b0);
        chk({29'h0, ale_o, pss_o, p0f}, 32'h6);
        wr(8'h04, 32'h01);
        rst_pin <= 1'b1;
        repeat (30) @(posedge pclk);
        chk1(ram_wb, 1'b1);
        rst_pin <= 1'b0;
        repeat (40) @(posedge pclk);
        rd(8'h00, 32'h0);
        chk1(stall, 1'b0);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
